// ---- lfr_pkg.sv ----
// Package for the line-up fault, resonance and general pin monitor.
// Assumes a single 10 MHz core clock and plain configuration ports from the host register file.
package lfr_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS          = 100;
	localparam int SETTLE_TIME_NS  = 2000;
	localparam int SETTLE_CYCLES   = (SETTLE_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int BOOST_STEPS     = 16;
	localparam int STEP_TIME_NS    = 20000;
	localparam int STEP_CYCLES     = STEP_TIME_NS / CLK_NS;
	localparam int PK_CH           = 3;
	localparam int REF_W           = 6;

	// ------------------------------------------------------------
	// Peak channel indices
	// ------------------------------------------------------------
	localparam int PK_AMP          = 0;
	localparam int PK_FILT         = 1;
	localparam int PK_RECV         = 2;

	// ------------------------------------------------------------
	// General pin output sources
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		GP_SRC_LOW,
		GP_SRC_HIGH,
		GP_SRC_OSC,
		GP_SRC_OSC_DIV4,
		GP_SRC_DRAIN_CMP,
		GP_SRC_BOOST_DISC,
		GP_SRC_PK_TEST
	} lfr_gp_src_t;

	typedef struct packed {
		logic        is_output;
		lfr_gp_src_t src;
		logic        to_converter;
	} lfr_gp_cfg_t;

	typedef struct packed {
		logic             enable;
		logic             sleep_off;
		logic [PK_CH-1:0][REF_W-1:0] ref_level;
		logic [PK_CH-1:0][REF_W-1:0] diode_comp;
		logic [1:0]       test_sel;
	} lfr_pk_cfg_t;

	typedef struct packed {
		logic enable;
		logic fast_off;
		logic slow_off;
		logic sleep_off;
	} lfr_res_cfg_t;

	localparam logic [1:0] DIV4_LAST = 2'h3;

endpackage : lfr_pkg

// ---- lfr_sync.sv ----
// Two-stage level synchroniser, a vector of independent bits.
// Assumes inputs change asynchronously to clk_sys.
`timescale 1ns/1ps
module lfr_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			meta_r <= '0;
			q      <= '0;
		end
		else if (ce)
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : lfr_sync

// ---- lfr_monitor.sv ----
// Peak detector auto protection, out-of-resonance detection and general pin routing.
// Assumes host register bits arrive as plain ports; comparator flags and gate-edge flip-flops are asynchronous.
`timescale 1ns/1ps
module lfr_monitor
	import lfr_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 ce,
	input  wire logic                 sleep_pin,
	input  wire logic                 sleep_pol_low,
	input  wire lfr_pkg::lfr_pk_cfg_t pk_cfg,
	input  wire logic [2:0]           pk_cmp_async,
	output logic                      pk_active,
	output logic [2:0]                pk_flag,
	output logic [2:0][5:0]           pk_ref_out,
	input  wire logic                 amp_en_wr,
	input  wire logic                 amp_en_val,
	input  wire logic                 boost_en_wr,
	input  wire logic                 boost_en_val,
	input  wire logic                 relay_on_in,
	input  wire logic                 boost_ramp_done,
	output logic                      amp_en,
	output logic                      boost_en,
	output logic                      relay_force_off,
	output logic                      pd_busy,
	input  wire lfr_pkg::lfr_res_cfg_t res_cfg,
	input  wire logic                 slow_ff_async,
	input  wire logic                 fast_ff_async,
	output logic                      gate_bias_en,
	output logic                      res_det_armed,
	output logic                      resonance_shift_sense,
	output logic                      resonance_shift_irq,
	output logic                      fast_detect_live,
	output logic                      slow_detect_live,
	input  wire logic                 irq_read,
	input  wire lfr_pkg::lfr_gp_cfg_t gp1_cfg,
	input  wire lfr_pkg::lfr_gp_cfg_t gp2_cfg,
	input  wire logic                 gp_sleep_off,
	input  wire logic                 osc_clock_node,
	input  wire logic                 drain_cmp,
	input  wire logic                 boost_disc_hi,
	input  wire logic                 boost_disc_lo,
	input  wire logic                 pk_env_test,
	input  wire logic                 pk_ref_test,
	input  wire logic                 general_pin_one_in,
	input  wire logic                 general_pin_two_in,
	output logic                      general_pin_one_out,
	output logic                      general_pin_one_oe,
	output logic                      general_pin_two_out,
	output logic                      general_pin_two_oe,
	output logic [1:0]                gp_to_converter,
	output logic [1:0]                gp_sense,
	output logic [1:0]                gp_irq
);
	// ------------------------------------------------------------
	// Synchronisers and sleep
	// ------------------------------------------------------------
	logic [2:0] pk_cmp_s;
	logic [1:0] res_s;
	logic [1:0] gp_in_s;
	logic       sleep;

	lfr_sync #(.W(7)) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.ce      (ce),
		.d       ({pk_cmp_async, slow_ff_async, fast_ff_async, general_pin_two_in, general_pin_one_in}),
		.q       ({pk_cmp_s, res_s, gp_in_s})
	);

	assign sleep = sleep_pin ^ sleep_pol_low;

	// ------------------------------------------------------------
	// Peak detectors
	// ------------------------------------------------------------
	always_comb
	begin
		pk_active = pk_cfg.enable && !(sleep && pk_cfg.sleep_off);
		pk_flag   = pk_active ? pk_cmp_s : 3'h0;
	end

	// Reference sits above the threshold by the diode drop lost in the rectifier.
	always_comb
	begin
		for (int i = 0; i < PK_CH; i++)
			pk_ref_out[i] = pk_cfg.ref_level[i] + pk_cfg.diode_comp[i];
	end

	logic amp_fault;
	logic rx_fault;
	assign amp_fault = pk_flag[PK_AMP] | pk_flag[PK_FILT];
	assign rx_fault  = pk_flag[PK_RECV];

	// ------------------------------------------------------------
	// Auto protection
	// ------------------------------------------------------------
	typedef enum logic [1:0] {PD_IDLE, PD_RAMP, PD_DRV_OFF} lfr_pd_t;
	lfr_pd_t pd_r;
	logic    amp_req_r;
	logic    boost_req_r;
	logic    relay_off_r;
	logic    trig;
	logic    block_hold;

	// Relay off: amp fault or any receive fault while off; on: only amp fault.
	assign trig       = amp_en && boost_en && (relay_on_in ? amp_fault : (amp_fault | rx_fault));
	assign block_hold = !(amp_en || boost_en) && (relay_on_in ? amp_fault : rx_fault);
	assign pd_busy    = pd_r != PD_IDLE;

	// Written enables are parked here and applied only when the protection allows.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			amp_req_r   <= 1'b0;
			boost_req_r <= 1'b0;
		end
		else if (ce)
		begin
			if (trig)
			begin
				amp_req_r   <= amp_en_wr ? amp_en_val : 1'b0;
				boost_req_r <= boost_en_wr ? boost_en_val : 1'b0;
			end
			else
			begin
				if (amp_en_wr)
					amp_req_r <= amp_en_val;
				if (boost_en_wr)
					boost_req_r <= boost_en_val;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			pd_r <= PD_IDLE;
		else if (ce)
		begin
			case (pd_r)
				PD_IDLE:
					if (trig)
						pd_r <= PD_RAMP;
				PD_RAMP:
					if (boost_ramp_done)
						pd_r <= PD_DRV_OFF;
				PD_DRV_OFF:
					pd_r <= PD_IDLE;
				default:
					pd_r <= PD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			amp_en   <= 1'b0;
			boost_en <= 1'b0;
		end
		else if (ce)
		begin
			if (trig)
				boost_en <= 1'b0;
			else if (pd_r == PD_RAMP)
				boost_en <= 1'b0;
			else if (pd_r == PD_DRV_OFF)
			begin
				amp_en   <= 1'b0;
				boost_en <= 1'b0;
			end
			else if (!block_hold)
			begin
				amp_en   <= amp_req_r;
				boost_en <= boost_req_r;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			relay_off_r <= 1'b0;
		else if (ce)
		begin
			if (block_hold && relay_on_in && amp_fault)
				relay_off_r <= 1'b1;
			else if (!pk_active)
				relay_off_r <= 1'b0;
		end
	end
	assign relay_force_off = relay_off_r;

	// ------------------------------------------------------------
	// Out-of-resonance detection
	// ------------------------------------------------------------
	logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_r;
	logic res_en;
	logic slow_hit;
	logic fast_hit;
	logic sense_r;
	logic irq_r;

	assign res_en       = res_cfg.enable && !(sleep && res_cfg.sleep_off);
	assign gate_bias_en = res_en;
	assign res_det_armed = res_en && (settle_r == '0);
	assign slow_hit     = res_det_armed && !res_cfg.slow_off && res_s[1];
	assign fast_hit     = res_det_armed && !res_cfg.fast_off && res_s[0];

	// The detector flops glitch while bias settles, so events are masked until the count expires.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			settle_r <= ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES);
		else if (ce)
		begin
			if (!res_en)
				settle_r <= ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES);
			else if (settle_r != '0)
				settle_r <= settle_r - 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			sense_r <= 1'b0;
			irq_r   <= 1'b0;
		end
		else if (ce)
		begin
			if (slow_hit)
				sense_r <= 1'b1;
			else if (fast_hit)
				sense_r <= 1'b0;
			if (slow_hit || fast_hit)
				irq_r <= 1'b1;
			else if (irq_read)
				irq_r <= 1'b0;
		end
	end

	// Slow wins the sense bit when both fire together; the live bits still show each.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			fast_detect_live <= 1'b0;
			slow_detect_live <= 1'b0;
		end
		else if (ce)
		begin
			fast_detect_live <= fast_hit;
			slow_detect_live <= slow_hit;
		end
	end
	assign resonance_shift_sense = sense_r;
	assign resonance_shift_irq   = irq_r;

	// ------------------------------------------------------------
	// General pins
	// ------------------------------------------------------------
	logic [1:0] div_r;
	logic [1:0] gp_prev_r;
	logic [1:0] gp_irq_r;
	logic       gp_off;

	assign gp_off = sleep && gp_sleep_off;

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
			div_r <= 2'h0;
		else if (ce)
			div_r <= div_r + 2'h1;
	end

	function automatic logic gp_pick(input lfr_gp_src_t s, input logic disc, input logic drain, input logic test,
		input logic [1:0] div);
		case (s)
			GP_SRC_LOW:        gp_pick = 1'b0;
			GP_SRC_HIGH:       gp_pick = 1'b1;
			GP_SRC_OSC:        gp_pick = osc_clock_node;
			GP_SRC_OSC_DIV4:   gp_pick = div[1];
			GP_SRC_DRAIN_CMP:  gp_pick = drain;
			GP_SRC_BOOST_DISC: gp_pick = disc;
			GP_SRC_PK_TEST:    gp_pick = test;
			default:           gp_pick = 1'b0;
		endcase
	endfunction : gp_pick

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			general_pin_one_out <= 1'b0;
			general_pin_two_out <= 1'b0;
		end
		else if (ce)
		begin
			general_pin_one_out <= gp_pick(gp1_cfg.src, boost_disc_hi, 1'b0,
				pk_cfg.test_sel != 2'h0 ? pk_env_test : 1'b0, div_r);
			general_pin_two_out <= gp_pick(gp2_cfg.src, boost_disc_lo, drain_cmp,
				pk_cfg.test_sel != 2'h0 ? pk_ref_test : 1'b0, div_r);
		end
	end

	assign general_pin_one_oe = gp1_cfg.is_output && !gp_off;
	assign general_pin_two_oe = gp2_cfg.is_output && !gp_off;
	assign gp_to_converter[0] = !gp_off && !gp1_cfg.is_output && gp1_cfg.to_converter;
	assign gp_to_converter[1] = !gp_off && (gp2_cfg.is_output ? (gp2_cfg.src == GP_SRC_DRAIN_CMP && gp2_cfg.to_converter)
		: gp2_cfg.to_converter);

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			gp_prev_r <= 2'h0;
			gp_irq_r  <= 2'h0;
		end
		else if (ce)
		begin
			gp_prev_r <= gp_in_s;
			for (int i = 0; i < 2; i++)
			begin
				if ((i == 0 ? !gp1_cfg.is_output : !gp2_cfg.is_output) && !gp_off && gp_in_s[i] != gp_prev_r[i])
					gp_irq_r[i] <= 1'b1;
				else if (irq_read)
					gp_irq_r[i] <= 1'b0;
			end
		end
	end
	assign gp_sense = gp_in_s;
	assign gp_irq   = gp_irq_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_amp_fault_or: assert property (@(posedge clk_sys) disable iff (!resetn)
		amp_fault == (pk_active && (pk_cmp_s[PK_AMP] || pk_cmp_s[PK_FILT]))) else $error("amp fault not OR");
	chk_pk_inactive_flags: assert property (@(posedge clk_sys) disable iff (!resetn)
		!pk_active |-> pk_flag == 3'h0) else $error("flag while disabled");
	chk_pd_boost_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && trig |=> !boost_en) else $error("boost stays on after fault");
	chk_pd_amp_order: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && pd_r == PD_RAMP && !boost_ramp_done |=> pd_r == PD_RAMP) else $error("ramp left early");
	chk_pd_hold_en: assert property (@(posedge clk_sys) disable iff (!resetn)
		pd_r == PD_RAMP |=> !boost_en) else $error("enable applied mid ramp");
	chk_res_irq_set: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && (slow_hit || fast_hit) |=> resonance_shift_irq) else $error("irq not set");
	chk_res_sense_slow: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && slow_hit |=> resonance_shift_sense) else $error("sense not set on slow");
	chk_res_sense_fast: assert property (@(posedge clk_sys) disable iff (!resetn)
		ce && fast_hit && !slow_hit |=> !resonance_shift_sense) else $error("sense not cleared on fast");
	chk_res_settle_mask: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(res_en) |-> !res_det_armed [*8]) else $error("detection armed before settling");
	chk_bias_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
		!res_en |-> !gate_bias_en && !fast_hit && !slow_hit) else $error("bias on while disabled");
	chk_gp_sleep_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		gp_off |-> !general_pin_one_oe && !general_pin_two_oe) else $error("pin driven in sleep");
endmodule : lfr_monitor

// ---- lfr_lineup_model.sv ----
// Model of the analogue line-up behind the monitor: the boost ramp-down.
// Assumes the monitor's boost enable and the shared core clock and reset.
`timescale 1ns/1ps
module lfr_lineup_model #(
	parameter int RAMP = 10
) (
	input  wire logic clk_sys,
	input  wire logic resetn,
	input  wire logic boost_en,
	output logic      boost_ramp_done
);
	logic [7:0] ramp_cnt_r;

	// --------------------
	// Boost ramp
	// --------------------
	// Done is only flagged once the output has fully fallen, never early, so parked enables are exposed.
	always_ff @(posedge clk_sys)
	begin
		if (!resetn || boost_en)
			ramp_cnt_r <= 8'h00;
		else if (ramp_cnt_r != 8'(RAMP))
			ramp_cnt_r <= ramp_cnt_r + 8'h01;
	end

	assign boost_ramp_done = !boost_en && (ramp_cnt_r == 8'(RAMP));
endmodule : lfr_lineup_model

// ---- lfr_monitor_tb.sv ----
// Self-checking bench for the line-up fault, resonance and general pin monitor.
// Assumes lfr_pkg, the monitor and the line-up model are compiled first.
`timescale 1ns/1ps
module lfr_monitor_tb;
	import lfr_pkg::*;
	logic            clk_sys, resetn, ce, sleep_pin, sleep_pol_low, pk_active, irq_read, gp_sleep_off;
	logic            amp_en_wr, amp_en_val, boost_en_wr, boost_en_val, relay_on_in, boost_ramp_done;
	logic            amp_en, boost_en, relay_force_off, pd_busy, slow_ff_async, fast_ff_async, gate_bias_en;
	logic            res_det_armed, resonance_shift_sense, resonance_shift_irq, fast_detect_live, slow_detect_live;
	logic            osc_clock_node, drain_cmp, boost_disc_hi, boost_disc_lo, pk_env_test, pk_ref_test;
	logic            general_pin_one_in, general_pin_two_in, general_pin_one_out, general_pin_one_oe;
	logic            general_pin_two_out, general_pin_two_oe;
	logic [1:0]      gp_to_converter, gp_sense, gp_irq;
	logic [2:0]      pk_cmp_async, pk_flag;
	logic [2:0][5:0] pk_ref_out;
	lfr_pk_cfg_t     pk_cfg;
	lfr_res_cfg_t    res_cfg;
	lfr_gp_cfg_t     gp1_cfg, gp2_cfg, cfg;
	int              bad_count, total_checks;

	lfr_monitor u_lfr_monitor (.clk_sys, .resetn, .ce, .sleep_pin, .sleep_pol_low, .pk_cfg, .pk_cmp_async,
		.pk_active, .pk_flag, .pk_ref_out, .amp_en_wr, .amp_en_val, .boost_en_wr, .boost_en_val, .relay_on_in,
		.boost_ramp_done, .amp_en, .boost_en, .relay_force_off, .pd_busy, .res_cfg, .slow_ff_async, .fast_ff_async,
		.gate_bias_en, .res_det_armed, .resonance_shift_sense, .resonance_shift_irq, .fast_detect_live,
		.slow_detect_live, .irq_read, .gp1_cfg, .gp2_cfg, .gp_sleep_off, .osc_clock_node, .drain_cmp,
		.boost_disc_hi, .boost_disc_lo, .pk_env_test, .pk_ref_test, .general_pin_one_in, .general_pin_two_in,
		.general_pin_one_out, .general_pin_one_oe, .general_pin_two_out, .general_pin_two_oe, .gp_to_converter,
		.gp_sense, .gp_irq);
	lfr_lineup_model u_lfr_lineup_model (.clk_sys, .resetn, .boost_en, .boost_ramp_done);

	// --------------------
	// Clock, helpers
	// --------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	task automatic chk1(logic got, logic exp, string what);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chk1

	task automatic chkv(logic [7:0] got, logic [7:0] exp, string what);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chkv

	task automatic test_end(string name);
		$display("%s done, checks %0d, mismatches %0d", name, total_checks, bad_count);
	endtask : test_end

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic wr_en(logic v);
		amp_en_wr = 1'b1;
		boost_en_wr = 1'b1;
		amp_en_val = v;
		boost_en_val = v;
		cyc(1);
		amp_en_wr = 1'b0;
		boost_en_wr = 1'b0;
	endtask : wr_en

	task automatic host_read;
		irq_read = 1'b1;
		cyc(1);
		irq_read = 1'b0;
		cyc(2);
	endtask : host_read

	// Drives the gate-edge flops with drv; the live bits must equal exp while driven and drop afterwards.
	task automatic ff_hit(logic [1:0] drv, logic [1:0] exp);
		{slow_ff_async, fast_ff_async} = drv;
		cyc(4);
		chkv({6'h00, slow_detect_live, fast_detect_live}, {6'h00, exp}, "live bits");
		{slow_ff_async, fast_ff_async} = 2'h0;
		cyc(4);
		chkv({6'h00, slow_detect_live, fast_detect_live}, 8'h00, "live idle");
	endtask : ff_hit

	function automatic logic [5:0] ref_sum(logic [5:0] a, logic [5:0] b);
		return a + b;
	endfunction : ref_sum

	function automatic logic gp_expect(int p, int s);
		case (s)
			0: return 1'b0;
			1: return 1'b1;
			2: return osc_clock_node;
			4: return drain_cmp;
			5: return (p == 0) ? boost_disc_hi : boost_disc_lo;
			default: return (p == 0) ? pk_env_test : pk_ref_test;
		endcase
	endfunction : gp_expect

	function automatic logic pin_out(int p);
		return p ? general_pin_two_out : general_pin_one_out;
	endfunction : pin_out

	// Divide-by-4 output inverts every second cycle; with ce low it must stand still.
	task automatic div4_check(int p);
		logic v0;
		logic v1;
		v0 = pin_out(p);
		cyc(1);
		v1 = pin_out(p);
		cyc(1);
		chk1(pin_out(p), !v0, "div4 first half");
		cyc(1);
		chk1(pin_out(p), !v1, "div4 second half");
		ce = 1'b0;
		v0 = pin_out(p);
		cyc(3);
		chk1(pin_out(p), v0, "frozen by ce");
		ce = 1'b1;
	endtask : div4_check

	// --------------------
	// Watchdog
	// --------------------
	initial
	begin
		#2000000;
		bad_count++;
		tally_and_finish();
	end

	// --------------------
	// Tests
	// --------------------
	initial
	begin
		{ce, sleep_pin, sleep_pol_low, amp_en_wr, amp_en_val, boost_en_wr, boost_en_val, relay_on_in} = '0;
		{slow_ff_async, fast_ff_async, irq_read, gp_sleep_off, osc_clock_node, drain_cmp, boost_disc_hi} = '0;
		{boost_disc_lo, pk_env_test, pk_ref_test, general_pin_one_in, general_pin_two_in, resetn} = '0;
		{pk_cmp_async, pk_cfg, res_cfg, gp1_cfg, gp2_cfg, cfg} = '0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'h71D4));
		ce = 1'b1;
		cyc(12);
		resetn = 1'b1;
		cyc(1);
		chkv({4'h0, amp_en, boost_en, pk_active, gate_bias_en}, 8'h00, "reset state");
		for (int i = 0; i < 3; i++)
		begin
			pk_cfg.ref_level[i] = (i == 0) ? 6'h3F : 6'($urandom);
			pk_cfg.diode_comp[i] = (i == 0) ? 6'h3F : 6'($urandom);
		end
		cyc(1);
		for (int i = 0; i < 3; i++)
			chkv({2'h0, pk_ref_out[i]}, {2'h0, ref_sum(pk_cfg.ref_level[i], pk_cfg.diode_comp[i])}, "ref");
		pk_cmp_async = 3'h7;
		cyc(4);
		chkv({5'h00, pk_flag}, 8'h00, "flags while off");
		pk_cfg.enable = 1'b1;
		cyc(4);
		chkv({5'h00, pk_flag}, 8'h07, "flags on");
		pk_cfg.sleep_off = 1'b1;
		sleep_pin = 1'b1;
		cyc(1);
		chk1(pk_active, 1'b0, "sleep high");
		sleep_pol_low = 1'b1;
		cyc(1);
		chk1(pk_active, 1'b1, "inverted sleep");
		{sleep_pin, sleep_pol_low, pk_cmp_async} = '0;
		cyc(4);
		test_end("peak");
		wr_en(1'b1);
		cyc(3);
		relay_on_in = 1'b1;
		pk_cmp_async = 3'h2;
		cyc(5);
		chkv({4'h0, amp_en, boost_en, pd_busy, relay_force_off}, 8'h0A, "pd start relay on");
		pk_cmp_async = 3'h0;
		wr_en(1'b1);
		cyc(2);
		chk1(boost_en, 1'b0, "parked enable");
		cyc(20);
		chkv({5'h00, amp_en, boost_en, pd_busy}, 8'h06, "parked applied");
		relay_on_in = 1'b0;
		pk_cmp_async = 3'h4;
		cyc(5);
		chk1(pd_busy, 1'b1, "pd relay off");
		pk_cmp_async = 3'h0;
		cyc(20);
		chkv({4'h0, amp_en, boost_en, pd_busy, relay_force_off}, 8'h00, "pd end");
		relay_on_in = 1'b1;
		pk_cmp_async = 3'h1;
		cyc(5);
		chk1(relay_force_off, 1'b1, "relay off");
		wr_en(1'b1);
		cyc(4);
		chk1(amp_en, 1'b0, "held enable");
		pk_cmp_async = 3'h0;
		cyc(8);
		chkv({6'h00, amp_en, boost_en}, 8'h03, "fault cleared");
		wr_en(1'b0);
		relay_on_in = 1'b0;
		cyc(3);
		test_end("protect");
		res_cfg.enable = 1'b1;
		cyc(1);
		chk1(gate_bias_en, 1'b1, "bias on");
		slow_ff_async = 1'b1;
		cyc(3);
		slow_ff_async = 1'b0;
		cyc(4);
		chk1(resonance_shift_irq, 1'b0, "settle mask");
		cyc(SETTLE_CYCLES - 9);
		chk1(res_det_armed, 1'b0, "armed early");
		cyc(1);
		chk1(res_det_armed, 1'b1, "armed after settle");
		ff_hit(2'h2, 2'h2);
		chkv({6'h00, resonance_shift_irq, resonance_shift_sense}, 8'h03, "slow");
		host_read();
		chkv({6'h00, resonance_shift_irq, resonance_shift_sense}, 8'h01, "read clears");
		ff_hit(2'h1, 2'h1);
		chkv({6'h00, resonance_shift_irq, resonance_shift_sense}, 8'h02, "fast");
		host_read();
		res_cfg.fast_off = 1'b1;
		ff_hit(2'h1, 2'h0);
		chk1(resonance_shift_irq, 1'b0, "fast off");
		res_cfg.fast_off = 1'b0;
		res_cfg.slow_off = 1'b1;
		ff_hit(2'h3, 2'h1);
		chkv({6'h00, resonance_shift_irq, resonance_shift_sense}, 8'h02, "slow off");
		res_cfg.sleep_off = 1'b1;
		sleep_pin = 1'b1;
		cyc(1);
		chk1(gate_bias_en, 1'b0, "bias sleep");
		sleep_pin = 1'b0;
		test_end("resonance");
		pk_cfg.test_sel = 2'h1;
		for (int p = 0; p < 2; p++)
			for (int s = 0; s < 7; s++)
			begin
				if (p == 0 && s == 4)
					continue;
				{osc_clock_node, drain_cmp, boost_disc_hi, boost_disc_lo, pk_env_test, pk_ref_test} = 6'($urandom);
				cfg = '{1'b1, lfr_gp_src_t'(s), s == 4};
				if (p == 0)
					gp1_cfg = cfg;
				else
					gp2_cfg = cfg;
				cyc(5);
				chk1(p ? general_pin_two_oe : general_pin_one_oe, 1'b1, "pin drives");
				if (s == 3)
					div4_check(p);
				else
					chk1(pin_out(p), gp_expect(p, s), "pin source");
				if (s == 4)
					chk1(gp_to_converter[1], 1'b1, "drain to converter");
			end
		gp1_cfg = '{1'b0, GP_SRC_LOW, 1'b1};
		cyc(2);
		chkv({5'h00, general_pin_one_oe, gp_to_converter[0], general_pin_two_oe}, 8'h03, "input mode");
		general_pin_one_in = 1'b1;
		general_pin_two_in = 1'b1;
		cyc(5);
		chkv({6'h00, gp_sense[0], gp_irq[0]}, 8'h03, "input sensed");
		chkv({6'h00, gp_irq}, 8'h01, "output pin no flag");
		host_read();
		chk1(gp_irq[0], 1'b0, "pin irq read");
		gp2_cfg = '{1'b1, GP_SRC_HIGH, 1'b0};
		sleep_pin = 1'b1;
		cyc(4);
		chkv({6'h00, general_pin_two_oe, general_pin_two_out}, 8'h03, "sleep keeps");
		gp_sleep_off = 1'b1;
		cyc(4);
		chk1(general_pin_two_oe, 1'b0, "sleep disables");
		test_end("pins");
		tally_and_finish();
	end
endmodule : lfr_monitor_tb
